// ### dv/testbench.sv
// Self-checking bench for the line driver and drive monitor
`timescale 1ns/1ps
module testbench;
  import tldm_pkg::*;
  localparam int LIM = 8;
  logic i_mclk, i_rst, i_sym_valid, i_transmit_on, i_transmit_on_bit, i_host_mode;
  logic i_int_mon_sel, cut, mon_p, mon_n, o_sym_ready, lp, lp_oe_n, ln, ln_oe_n, fault;
  logic [TLDM_SYM_W-1:0] i_sym;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  tldm_top #(.IDLE_LIMIT(LIM)) DUT (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_sym_valid(i_sym_valid), .o_sym_ready(o_sym_ready), .i_sym(i_sym),
    .i_transmit_on(i_transmit_on), .i_transmit_on_bit(i_transmit_on_bit),
    .i_host_mode(i_host_mode), .i_int_mon_sel(i_int_mon_sel),
    .i_monitor_in_pos(mon_p), .i_monitor_in_neg(mon_n), .o_line_out_pos(lp),
    .o_line_out_pos_oe_n(lp_oe_n), .o_line_out_neg(ln), .o_line_out_neg_oe_n(ln_oe_n),
    .o_drive_fault_flag(fault));
  tldm_line_model line (.i_line_out_pos(lp), .i_line_out_pos_oe_n(lp_oe_n),
    .i_line_out_neg(ln), .i_line_out_neg_oe_n(ln_oe_n), .i_cut(cut),
    .o_monitor_in_pos(mon_p), .o_monitor_in_neg(mon_n));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    i_mclk = 1'h0;
    forever #20 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [1:0] seen, input logic [1:0] want);
    compares++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic send(input logic [1:0] s);
    @(negedge i_mclk);
    while (o_sym_ready !== 1'h1) @(negedge i_mclk);
    i_sym_valid = 1'h1;
    i_sym = s;
    @(negedge i_mclk);
    i_sym_valid = 1'h0;
  endtask
  task automatic expect_line(input logic [1:0] want);
    for (int k = 0; k < 8 && {lp, ln} !== want; k++) @(negedge i_mclk);
    check({lp, ln}, want);
  endtask
  task automatic give_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_polarity();
    send(2'h2);
    expect_line(2'h2);
    check({lp_oe_n, ln_oe_n}, 2'h0);
    send(2'h1);
    expect_line(2'h1);
    send(2'h3);
    @(negedge i_mclk);
    check({lp, ln}, 2'h0);
  endtask
  task automatic t_off_fill();
    i_transmit_on = 1'h0;
    repeat (2) @(negedge i_mclk);
    check({lp_oe_n, ln_oe_n}, 2'h3);
    for (int k = 0; k < 4; k++) send(k[0] ? 2'h1 : 2'h2);
    check({1'h0, o_sym_ready}, 2'h0);
    i_transmit_on = 1'h1;
    i_host_mode = 1'h1;
    repeat (2) @(negedge i_mclk);
    check({lp_oe_n, ln_oe_n}, 2'h3);
    i_transmit_on_bit = 1'h1;
    expect_line(2'h2);
    @(negedge i_mclk);
    check({lp, ln}, 2'h1);
  endtask
  task automatic t_idle();
    send(2'h2);
    expect_line(2'h2);
    repeat (LIM) @(negedge i_mclk);
    check({1'h0, fault}, 2'h0);
    @(negedge i_mclk);
    check({1'h0, fault}, 2'h1);
    send(2'h1);
    repeat (2) @(negedge i_mclk);
    check({1'h0, fault}, 2'h0);
  endtask
  task automatic t_source();
    cut = 1'h1;
    i_int_mon_sel = 1'h1;
    repeat (LIM + 4) send(2'h2);
    check({1'h0, fault}, 2'h0);
    i_host_mode = 1'h0;
    repeat (LIM + 4) send(2'h1);
    check({1'h0, fault}, 2'h1);
    cut = 1'h0;
    send(2'h2);
    repeat (3) @(negedge i_mclk);
    check({1'h0, fault}, 2'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {i_sym_valid, i_transmit_on_bit, i_host_mode, i_int_mon_sel, cut} = 5'h00;
    i_transmit_on = 1'h1;
    i_sym = 2'h0;
    i_rst = 1'h1;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'h0;
    t_polarity();
    t_off_fill();
    t_idle();
    t_source();
    give_verdict();
  end
endmodule

// ### dv/tldm_line_model.sv
// Line transformer and cable model that feeds the monitor pair
`timescale 1ns/1ps
module tldm_line_model (
  input wire logic i_line_out_pos, // Positive line value
  input wire logic i_line_out_pos_oe_n, // Low while positive drives
  input wire logic i_line_out_neg, // Negative line value
  input wire logic i_line_out_neg_oe_n, // Low while negative drives
  input wire logic i_cut, // Open cable fault
  output logic o_monitor_in_pos, // Monitor positive
  output logic o_monitor_in_neg // Monitor negative
);
  // Winding ties a released or cut pair to one level, so no pulse shows
  assign o_monitor_in_pos = (i_cut || i_line_out_pos_oe_n) ? 1'h0 : i_line_out_pos;
  assign o_monitor_in_neg = (i_cut || i_line_out_neg_oe_n) ? 1'h0 : i_line_out_neg;
endmodule

// ### src/tldm_fifo.sv
// Small synchronous FIFO for line symbols
`timescale 1ns/1ps
module tldm_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 4
) (
  input wire logic i_mclk, // Clock
  input wire logic i_rst, // Async reset
  input wire logic i_valid, // Write valid
  output logic o_ready, // Not full
  input wire logic [WIDTH-1:0] i_data, // Write data
  output logic o_valid, // Not empty
  input wire logic i_ready, // Read ready
  output logic [WIDTH-1:0] o_data // Read data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [AW:0] count;
  logic [AW:0] next_count;
  wire do_wr = i_valid && o_ready;
  wire do_rd = o_valid && i_ready;

  // Status and read port; ready is registered so it leaves from a flop
  assign next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  assign o_valid = (count != '0);
  assign o_data = mem[rd_ptr];

  // Wrapping pointer increment
  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'h1);
  endfunction

  // Storage
  always_ff @(posedge i_mclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= i_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_ready <= 1'h1;
    end else begin
      if (do_wr) wr_ptr <= inc(wr_ptr);
      if (do_rd) rd_ptr <= inc(rd_ptr);
      count <= next_count;
      o_ready <= (next_count != FULL);
    end
  end
endmodule

// ### src/tldm_pkg.sv
// Package of constants for the transmit line driver and drive monitor
// Behaviour
// - A positive line pulse drives the positive output high and the negative output low.
// - A negative line pulse drives the positive output low and the negative output high.
// - While the transmit-on control (pin or host bit) is 0 both line outputs float.
// - The monitor watches the positive and negative monitor inputs as a pair for pulses.
// - After 128 bit periods with no pulse the drive fault flag goes high.
// - With internal monitoring selected the external monitor inputs are ignored.
// - The fault flag stays low while a pulse was seen in the last 128 bit periods.
// - Internal monitoring can be selected only in host mode; hardware mode uses the pins.
package tldm_pkg;
  localparam int unsigned TLDM_IDLE_LIMIT = 128;
  localparam int unsigned TLDM_CNT_W = 8;
  localparam logic [TLDM_CNT_W-1:0] TLDM_CNT_RST = 8'h00;
  localparam int unsigned TLDM_FIFO_DEPTH = 4;
  localparam int unsigned TLDM_SYM_W = 2;
  // Symbol layout: bit 1 positive pulse, bit 0 negative pulse
  localparam int unsigned TLDM_SYM_POS = 1;
  localparam int unsigned TLDM_SYM_NEG = 0;
  localparam logic [1:0] TLDM_SYM_ZERO = 2'h0;
  typedef enum logic [1:0] {TLDM_OFF, TLDM_ON} tldm_state_t;
endpackage

// ### src/tldm_top.sv
// Transmit line driver with drive activity monitor, one channel
`timescale 1ns/1ps
module tldm_top #(
  parameter int unsigned IDLE_LIMIT = tldm_pkg::TLDM_IDLE_LIMIT,
  parameter int unsigned DEPTH = tldm_pkg::TLDM_FIFO_DEPTH
) (
  input wire logic i_mclk, // Transmit bit clock, 25 MHz
  input wire logic i_rst, // Async reset, active high
  input wire logic i_sym_valid, // Symbol offered
  output logic o_sym_ready, // FIFO can take a symbol
  input wire logic [tldm_pkg::TLDM_SYM_W-1:0] i_sym, // Bit1 positive, bit0 negative
  input wire logic i_transmit_on, // Transmit-on pin
  input wire logic i_transmit_on_bit, // Transmit-on host bit
  input wire logic i_host_mode, // 1 host mode, 0 hardware mode
  input wire logic i_int_mon_sel, // Internal monitoring select
  input wire logic i_monitor_in_pos, // External monitor positive
  input wire logic i_monitor_in_neg, // External monitor negative
  output logic o_line_out_pos, // Positive line output value
  output logic o_line_out_pos_oe_n, // Low while positive output drives
  output logic o_line_out_neg, // Negative line output value
  output logic o_line_out_neg_oe_n, // Low while negative output drives
  output logic o_drive_fault_flag // High after idle limit
);
  import tldm_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Control decode
  tldm_state_t state;
  tldm_state_t next_state;
  logic [TLDM_SYM_W-1:0] fifo_data;
  logic fifo_valid;
  wire tx_on = i_host_mode ? i_transmit_on_bit : i_transmit_on;
  wire use_int = i_host_mode && i_int_mon_sel;
  wire drain = (state == TLDM_ON); // FIFO read side open only while on
  wire take = fifo_valid && drain;
  wire [TLDM_SYM_W-1:0] cur_sym = take ? fifo_data : TLDM_SYM_ZERO;
  // Opposite polarities at once are not a legal symbol; send space
  wire sym_bad = cur_sym[TLDM_SYM_POS] && cur_sym[TLDM_SYM_NEG];
  wire next_pos = cur_sym[TLDM_SYM_POS] && !sym_bad;
  wire next_neg = cur_sym[TLDM_SYM_NEG] && !sym_bad;

  // Drain stalls while transmitter is off, so the FIFO back-pressures
  tldm_fifo #(.WIDTH(TLDM_SYM_W), .DEPTH(DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_valid(i_sym_valid),
    .o_ready(o_sym_ready),
    .i_data(i_sym),
    .o_valid(fifo_valid),
    .i_ready(drain),
    .o_data(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////
  // Transmitter on/off state
  always_comb begin
    next_state = state;
    case (state)
      TLDM_OFF: if (tx_on) next_state = TLDM_ON;
      TLDM_ON: if (!tx_on) next_state = TLDM_OFF;
      default: next_state = TLDM_OFF;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) state <= TLDM_OFF;
    else state <= next_state;
  end

  // Line drivers: enables follow transmit-on, levels follow symbol
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_line_out_pos <= 1'h0;
      o_line_out_neg <= 1'h0;
      o_line_out_pos_oe_n <= 1'h1;
      o_line_out_neg_oe_n <= 1'h1;
    end else begin
      o_line_out_pos <= next_pos;
      o_line_out_neg <= next_neg;
      o_line_out_pos_oe_n <= !tx_on;
      o_line_out_neg_oe_n <= !tx_on;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Drive monitor
  logic int_pos;
  logic int_neg;
  logic [TLDM_CNT_W-1:0] idle_cnt;
  // Internal copy of what is on the line; floating line shows nothing
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      int_pos <= 1'h0;
      int_neg <= 1'h0;
    end else begin
      int_pos <= next_pos && tx_on;
      int_neg <= next_neg && tx_on;
    end
  end

  wire mon_pos = use_int ? int_pos : i_monitor_in_pos;
  wire mon_neg = use_int ? int_neg : i_monitor_in_neg;
  // A pulse is the pair differing, either polarity
  wire pulse_seen = mon_pos ^ mon_neg;
  wire at_limit = (idle_cnt >= TLDM_CNT_W'(IDLE_LIMIT - 1));

  // Idle counter saturates at terminal count
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      idle_cnt <= TLDM_CNT_RST;
    end else if (pulse_seen) begin
      idle_cnt <= TLDM_CNT_RST;
    end else if (!at_limit) begin
      idle_cnt <= idle_cnt + 1'h1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) o_drive_fault_flag <= 1'h0;
    else o_drive_fault_flag <= !pulse_seen && at_limit;
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  // Last quiet count before the flag must rise
  localparam logic [TLDM_CNT_W:0] QUIET_LAST = (TLDM_CNT_W+1)'(IDLE_LIMIT - 1);
  logic [TLDM_CNT_W:0] quiet;
  // Symbols as they leave the FIFO toward the line
  wire chk_pos = take && fifo_data[TLDM_SYM_POS] && !fifo_data[TLDM_SYM_NEG];
  wire chk_neg = take && !fifo_data[TLDM_SYM_POS] && fifo_data[TLDM_SYM_NEG];
  wire chk_bad = take && fifo_data[TLDM_SYM_POS] && fifo_data[TLDM_SYM_NEG];

  // Reference quiet counter, kept apart from the design counter
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) quiet <= '0;
    else if (pulse_seen) quiet <= '0;
    else if (quiet != '1) quiet <= quiet + 1'h1;
  end

  // Line levels and drive enables
  pos_pulse_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    chk_pos |=> (o_line_out_pos && !o_line_out_neg))
    else $error("positive pulse not driven");

  neg_pulse_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    chk_neg |=> (!o_line_out_pos && o_line_out_neg))
    else $error("negative pulse not driven");

  bad_sym_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    chk_bad |=> (!o_line_out_pos && !o_line_out_neg))
    else $error("illegal symbol not sent as space");

  space_idle_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    !take |=> (!o_line_out_pos && !o_line_out_neg))
    else $error("line pulsed with nothing taken");

  tri_off_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    !tx_on |=> (o_line_out_pos_oe_n && o_line_out_neg_oe_n))
    else $error("line driven while off");

  on_drive_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    tx_on |=> (!o_line_out_pos_oe_n && !o_line_out_neg_oe_n))
    else $error("line floating while on");

  // Fault flag timing
  fault_set_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (quiet >= QUIET_LAST && !pulse_seen) |=> o_drive_fault_flag)
    else $error("fault not raised after idle limit");

  fault_hold_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (o_drive_fault_flag && !pulse_seen) |=> o_drive_fault_flag)
    else $error("fault dropped without a pulse");

  fault_clr_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    pulse_seen |=> !o_drive_fault_flag)
    else $error("fault high after pulse");

  fault_early_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (quiet < QUIET_LAST) |=> !o_drive_fault_flag)
    else $error("fault raised too early");

  // Monitor source selection
  ext_mon_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    !use_int |-> (pulse_seen == (i_monitor_in_pos ^ i_monitor_in_neg)))
    else $error("external pair not watched");

  int_ignore_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (use_int && (int_pos ~^ int_neg)) |-> !pulse_seen)
    else $error("external inputs seen in internal mode");

  int_seen_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (tx_on && chk_pos) |=> int_pos)
    else $error("internal copy missed a pulse");

  hw_ext_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (!i_host_mode && (i_monitor_in_pos ^ i_monitor_in_neg)) |=> idle_cnt == '0)
    else $error("hardware mode ignores pins");

  // Idle counter
  cnt_clear_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    pulse_seen |=> (idle_cnt == '0))
    else $error("counter not cleared by pulse");

  cnt_step_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (!pulse_seen && !at_limit) |=> (idle_cnt == $past(idle_cnt) + 1'h1))
    else $error("counter did not advance");

  cnt_sat_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (at_limit && !pulse_seen) |=> $stable(idle_cnt))
    else $error("counter moved past terminal count");
endmodule
